// file: acs_consts.vh
// Constants for the converter sequencer: offsets, fields, resets and timing.
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
`define ACS_OFF_DATA_LO    8'h00
`define ACS_OFF_DATA_HI    8'h04
`define ACS_OFF_CHAN       8'h08
`define ACS_OFF_RANGE      8'h0C
`define ACS_OFF_CTRL       8'h10
`define ACS_OFF_LEVEL      8'h14
`define ACS_OFF_FIFO_RST   8'h18
`define ACS_IDX_DATA       8'h00
`define ACS_IDX_CHAN       8'h02
`define ACS_IDX_RANGE      8'h03
`define ACS_IDX_CTRL       8'h04
`define ACS_BIT_BUSY       7
`define ACS_BIT_SETTLE     5
`define ACS_BIT_POLARITY   3
`define ACS_BIT_SWEEP      2
`define ACS_BIT_IRQ_TRIG   0
`define ACS_BIT_TRIG_SRC   4
`define ACS_BIT_OVERRUN    7
`define ACS_CHAN_RESET     8'h00
`define ACS_RANGE_RESET    8'h00
`define ACS_CTRL_RESET     8'h00
`define ACS_FIFO_SAMPLES   48
`define ACS_FIFO_BYTES     96
`define ACS_CLK_MHZ        100
`define ACS_SETTLE_US      10
`define ACS_SETTLE_CYC     (`ACS_SETTLE_US * `ACS_CLK_MHZ)
`define ACS_CONV_US        5
`define ACS_CONV_CYC       (`ACS_CONV_US * `ACS_CLK_MHZ)
`define ACS_RESP_OKAY      2'b00
`define ACS_RESP_SLVERR    2'b10
`endif

// file: acs_fifo.v
// Byte-wide result FIFO with fill level and overrun protection.
`timescale 1ns/10ps
`include "acs_consts.vh"
module acs_fifo (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clear,
    input  wire        push,
    input  wire [15:0] sample,
    input  wire        pop,
    output reg  [7:0]  rd_byte,
    output wire [6:0]  level_bytes,
    output wire        full
);
    reg [7:0] mem [0:`ACS_FIFO_BYTES-1];
    reg [6:0] wr_ptr_r;
    reg [6:0] rd_ptr_r;
    reg [6:0] count_r;
    wire      can_pop;
    wire [6:0] wr_next;

    // A sample needs two bytes of room, so full means fewer than two free.
    assign full        = (count_r > 7'd94);
    assign level_bytes = count_r;
    assign can_pop     = pop && (count_r != 7'd0);
    assign wr_next     = (wr_ptr_r == 7'd95) ? 7'd0 : wr_ptr_r + 7'd1;

    // Storage: low byte then high byte, read side destructive.
    always @(posedge aclk) begin
        if (push && !full) begin
            mem[wr_ptr_r] <= sample[7:0];
            mem[wr_next]  <= sample[15:8];
        end
        rd_byte <= mem[rd_ptr_r];
    end

    // Pointers and count; reset and clear empty the FIFO.
    always @(posedge aclk) begin
        if (!aresetn || clear) begin
            wr_ptr_r <= 7'd0;
            rd_ptr_r <= 7'd0;
            count_r  <= 7'd0;
        end else begin
            if (push && !full)
                wr_ptr_r <= (wr_next == 7'd95) ? 7'd0 : wr_next + 7'd1;
            if (can_pop)
                rd_ptr_r <= (rd_ptr_r == 7'd95) ? 7'd0 : rd_ptr_r + 7'd1;
            count_r <= count_r + ((push && !full) ? 7'd2 : 7'd0) - (can_pop ? 7'd1 : 7'd0);
        end
    end
endmodule

// file: acs_top.v
// Converter sequencer: AXI4-Lite registers, settling timer, trigger, scan and FIFO.
`timescale 1ns/10ps
`include "acs_consts.vh"
module acs_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        timer_trigger,
    input  wire        ext_trigger,
    input  wire [15:0] conv_result,
    output reg  [3:0]  conv_channel,
    output reg  [1:0]  gain_code,
    output reg         range_invalid
);
    localparam ST_IDLE = 2'd0;
    localparam ST_CONV = 2'd1;
    localparam ST_NEXT = 2'd2;
    localparam [9:0] SETTLE_CYC = `ACS_SETTLE_CYC;
    localparam [9:0] CONV_CYC   = `ACS_CONV_CYC;

    reg  [7:0]  chan_r;
    reg  [7:0]  range_r;
    reg  [7:0]  ctrl_r;
    reg  [3:0]  cur_r;
    reg  [9:0]  settle_r;
    reg  [9:0]  conv_cnt_r;
    reg  [1:0]  state_r;
    reg         busy_r;
    reg         overrun_r;
    reg  [7:0]  awaddr_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         aw_have_r;
    reg         w_have_r;
    reg         trig_d_r;
    reg         rd_pend_r;
    reg  [7:0]  rd_addr_r;
    reg         fifo_clear_r;
    wire        wr_fire;
    wire        wr_chan;
    wire        wr_range;
    wire        wr_trig;
    wire        hw_trig;
    wire        start;
    wire        push;
    wire        pop;
    wire [7:0]  fifo_byte;
    wire [6:0]  fifo_level;
    wire        fifo_full;

    // Byte-lane-0 write decoder shared by all register writes.
    function is_wr;
        input [7:0] addr;
        input [7:0] off;
        input [3:0] strb;
        begin
            is_wr = (addr == off) && strb[0];
        end
    endfunction

    assign wr_fire  = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_chan  = wr_fire && is_wr(awaddr_r, `ACS_OFF_CHAN, wstrb_r);
    assign wr_range = wr_fire && is_wr(awaddr_r, `ACS_OFF_RANGE, wstrb_r);
    assign wr_trig  = wr_fire && is_wr(awaddr_r, `ACS_OFF_DATA_LO, wstrb_r);
    assign hw_trig  = ctrl_r[`ACS_BIT_IRQ_TRIG] &&
                      (ctrl_r[`ACS_BIT_TRIG_SRC] ? ext_trigger : timer_trigger) && !trig_d_r;
    assign start    = (state_r == ST_IDLE) &&
                      ((wr_trig && !ctrl_r[`ACS_BIT_IRQ_TRIG]) || hw_trig);
    // no pushes after overrun until reset or a FIFO reset write
    assign push     = (state_r == ST_CONV) && (conv_cnt_r == 10'd1) && !fifo_full && !overrun_r;
    assign pop      = s_axi_arvalid && s_axi_arready &&
                      (s_axi_araddr == `ACS_OFF_DATA_LO || s_axi_araddr == `ACS_OFF_DATA_HI);

    // Write channel capture: address and data accepted in either order.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ACS_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_r[1:0] == 2'b00 && awaddr_r <= `ACS_OFF_FIFO_RST) ?
                                `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
            end
        end
    end

    // Software registers; reset clears window and gain.
    always @(posedge aclk) begin
        if (!aresetn) begin
            chan_r       <= `ACS_CHAN_RESET;
            range_r      <= `ACS_RANGE_RESET;
            ctrl_r       <= `ACS_CTRL_RESET;
            fifo_clear_r <= 1'b0;
        end else begin
            fifo_clear_r <= wr_fire && is_wr(awaddr_r, `ACS_OFF_FIFO_RST, wstrb_r);
            if (wr_chan)
                chan_r <= wdata_r[7:0];
            if (wr_range)
                range_r <= wdata_r[7:0] & 8'h0F;
            if (wr_fire && is_wr(awaddr_r, `ACS_OFF_CTRL, wstrb_r))
                ctrl_r <= wdata_r[7:0] & 8'h11;
        end
    end

    // settling timer restart on bus clock
    always @(posedge aclk) begin
        if (!aresetn)
            settle_r <= 10'd0;
        else if (wr_chan || wr_range)
            settle_r <= SETTLE_CYC;
        else if (settle_r != 10'd0)
            settle_r <= settle_r - 10'd1;
    end

    // Conversion sequencer: single or sweep, channel advance and overrun.
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r    <= ST_IDLE;
            busy_r     <= 1'b0;
            cur_r      <= 4'h0;
            conv_cnt_r <= 10'd0;
            overrun_r  <= 1'b0;
            trig_d_r   <= 1'b0;
        end else begin
            trig_d_r <= ctrl_r[`ACS_BIT_TRIG_SRC] ? ext_trigger : timer_trigger;
            // overrun set wins over FIFO reset
            if ((state_r == ST_CONV) && (conv_cnt_r == 10'd1) && fifo_full)
                overrun_r <= 1'b1;
            else if (fifo_clear_r)
                overrun_r <= 1'b0;
            case (state_r)
            ST_IDLE: begin
                if (wr_chan)
                    cur_r <= wdata_r[3:0];
                if (start) begin
                    state_r    <= ST_CONV;
                    busy_r     <= 1'b1;
                    conv_cnt_r <= CONV_CYC;
                end
            end
            ST_CONV: begin
                conv_cnt_r <= conv_cnt_r - 10'd1;
                if (conv_cnt_r == 10'd1)
                    state_r <= ST_NEXT;
            end
            ST_NEXT: begin
                cur_r <= (cur_r == chan_r[7:4]) ? chan_r[3:0] : cur_r + 4'h1;
                if (range_r[`ACS_BIT_SWEEP] && (cur_r != chan_r[7:4])) begin
                    state_r    <= ST_CONV;
                    conv_cnt_r <= CONV_CYC;
                end else begin
                    // busy drops after the last channel, or after one conversion when sweep is off
                    state_r <= ST_IDLE;
                    busy_r  <= 1'b0;
                end
            end
            default: begin
                state_r <= ST_IDLE;
                busy_r  <= 1'b0;
            end
            endcase
        end
    end

    // gain and range check, driven out to the analog front end
    always @(posedge aclk) begin
        if (!aresetn) begin
            conv_channel  <= 4'h0;
            gain_code     <= 2'b00;
            range_invalid <= 1'b0;
        end else begin
            conv_channel  <= cur_r;
            gain_code     <= range_r[1:0];
            range_invalid <= range_r[`ACS_BIT_POLARITY] && (range_r[1:0] == 2'b00);
        end
    end

    // results stored as two bytes, level counts them
    acs_fifo u_fifo (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .clear       (fifo_clear_r),
        .push        (push),
        .sample      (conv_result),
        .pop         (pop),
        .rd_byte     (fifo_byte),
        .level_bytes (fifo_level),
        .full        (fifo_full)
    );

    // Read channel: one cycle to accept, data two cycles after acceptance.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `ACS_RESP_OKAY;
            rd_pend_r     <= 1'b0;
            rd_addr_r     <= 8'h00;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !rd_pend_r && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                rd_pend_r <= 1'b1;
                rd_addr_r <= s_axi_araddr;
            end
            if (rd_pend_r) begin
                rd_pend_r    <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `ACS_RESP_OKAY;
                case (rd_addr_r)
                // empty FIFO gives whatever the RAM holds
                `ACS_OFF_DATA_LO,
                `ACS_OFF_DATA_HI: s_axi_rdata <= {24'h000000, fifo_byte};
                `ACS_OFF_CHAN:    s_axi_rdata <= {24'h000000, chan_r};
                `ACS_OFF_RANGE:   s_axi_rdata <= {24'h000000, busy_r, 1'b0, (settle_r != 10'd0), range_r[4:0]};
                `ACS_OFF_CTRL:    s_axi_rdata <= {24'h000000, ctrl_r};
                `ACS_OFF_LEVEL:   s_axi_rdata <= {24'h000000, overrun_r, fifo_level};
                `ACS_OFF_FIFO_RST: s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `ACS_RESP_SLVERR;
                end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// file: acs_conv_model.sv
// Converter stand-in that returns a sample built from the selected channel.
`timescale 1ns/10ps
module acs_conv_model (
    input  wire logic [15:0] base,
    input  wire logic [3:0]  conv_channel,
    output logic      [15:0] conv_result
);
    // Mixing in the channel makes a wrong channel show up as a wrong sample.
    assign conv_result = base ^ {12'h000, conv_channel};
endmodule

// file: acs_top_monitor.sv
// Checker for the sequencer's register bus and converter control ports.
`timescale 1ns/10ps
module acs_top_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [3:0]  conv_channel,
    input wire logic [1:0]  gain_code,
    input wire logic        range_invalid
);
    logic [7:0]  aw_r;
    logic [7:0]  ar_r;
    logic [7:0]  wd_r;
    logic [3:0]  lo_r;
    logic [10:0] set_r;
    wire         done = s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b00;
    wire         rdon = s_axi_rvalid && s_axi_rready;
    // Keeps the last address and data taken, and cycles since settling restarted.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_r  <= 8'h00;
            ar_r  <= 8'h00;
            wd_r  <= 8'h00;
            lo_r  <= 4'h0;
            set_r <= 11'h7FF;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
            if (s_axi_arvalid && s_axi_arready) ar_r <= s_axi_araddr;
            if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[7:0];
            if (done && aw_r == 8'h08) lo_r <= wd_r[3:0];
            if (done && (aw_r == 8'h08 || aw_r == 8'h0C)) set_r <= 11'h000;
            else if (set_r != 11'h7FF) set_r <= set_r + 11'h001;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_gain_write: assert property (done && aw_r == 8'h0C |=> gain_code == wd_r[1:0] &&
        range_invalid == (wd_r[3] && wd_r[1:0] == 2'h0)) else $error("gain or invalid flag wrong");
    a_chan_load: assert property (done && aw_r == 8'h08 |-> ##[0:3] conv_channel == wd_r[3:0])
        else $error("channel not loaded from low nibble");
    a_chan_step: assert property ($changed(conv_channel) |-> conv_channel == $past(conv_channel) + 4'h1 ||
        conv_channel == lo_r || conv_channel == wd_r[3:0]) else $error("channel stepped wrongly");
    a_settle_on: assert property (rdon && ar_r == 8'h0C && set_r < 11'd900 |-> s_axi_rdata[5])
        else $error("settling flag low too early");
    a_settle_off: assert property (rdon && ar_r == 8'h0C && set_r > 11'd1100 |-> !s_axi_rdata[5])
        else $error("settling flag stuck high");
    a_rd_unmapped: assert property (rdon && ar_r > 8'h18 |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_wr_unmapped: assert property (s_axi_bvalid && aw_r > 8'h18 |-> s_axi_bresp == 2'b10)
        else $error("unmapped write not refused");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    c_range: cover property (done && aw_r == 8'h0C);
    c_unmapped: cover property (rdon && ar_r > 8'h18);
    c_wrap: cover property ($changed(conv_channel) && conv_channel == lo_r);
endmodule

// file: tb_adc_conversion_sequencer.sv
// Self-checking bench for the converter sequencer over its register bus.
`timescale 1ns/10ps
module tb_adc_conversion_sequencer;
    logic        aclk, aresetn, awv, wv, brdy, arv, rrdy, tmr, ext;
    logic        awr, wr_r, bv, arr, rv, inv;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd, rdat;
    logic [15:0] base, cres, v;
    logic [1:0]  bresp, rresp, gain;
    logic [3:0]  ch;
    logic [2:0]  k;
    logic [65:0] e;
    logic [65:0] q[$];
    logic [15:0] res_q[$];
    int          error_cnt, checks, cyc;
    acs_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .timer_trigger(tmr), .ext_trigger(ext), .conv_result(cres), .conv_channel(ch), .gain_code(gain),
        .range_invalid(inv));
    acs_conv_model u_conv (.base(base), .conv_channel(ch), .conv_result(cres));
    task automatic chk(input logic [33:0] g, input logic [33:0] x);
        checks++;
        if (g !== x) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
        q.push_back({r, 64'h0});
        @(posedge aclk);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'($urandom);
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
            if (bv && !brdy) brdy <= 1'b1;
        end while (!(bv && brdy));
        brdy <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m, input logic [1:0] r = 2'b00);
        q.push_back({r, x, m});
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'($urandom);
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
            if (rv && !rrdy) rrdy <= 1'b1;
        end while (!(rv && rrdy));
        rd = rdat;
        rrdy <= 1'b0;
    endtask
    task automatic poll(input int b, input logic x);
        do rdr(8'h0C, 32'h0, 32'h0);
        while (rd[b] !== x);
    endtask
    task automatic run(input int lo, input int hi);
        base <= 16'($urandom);
        wr(8'h00, 8'h80);
        poll(7, 1'b0);
        for (int c = lo; c <= hi; c++) res_q.push_back(base ^ 16'(c));
    endtask
    task automatic drain();
        while (res_q.size() > 0) begin
            v = res_q.pop_front();
            rdr(8'h00, {24'h0, v[7:0]}, 32'hFFFFFFFF);
            rdr(8'h04, {24'h0, v[15:8]}, 32'hFFFFFFFF);
        end
    endtask
    // Clock at 100 MHz.
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Compares each bus answer against the oldest noted expectation.
    always @(posedge aclk) begin
        if ((rv && rrdy) || (bv && brdy)) begin
            e = q.pop_front();
            if (rv && rrdy) chk({rresp, rdat & e[31:0]}, {e[65:64], e[63:32] & e[31:0]});
            else chk({bresp, 32'h0}, {e[65:64], 32'h0});
        end
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // Main sequence.
    initial begin
        {aresetn, awv, wv, brdy, arv, rrdy, tmr, ext} = 8'h00;
        {awa, ara, wd, base} = 64'h0;
        void'($urandom(85450));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 8; a <= 20; a += 4) rdr(8'(a), 32'h0, 32'hFFFFFFFF);
        rdr(8'h1C, 32'h0, 32'hFFFFFFFF, 2'b10);
        wr(8'h1C, 8'h55, 2'b10);
        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            wr(8'h0C, {4'h0, k[2], 1'b0, k[1:0]});
            @(posedge aclk);
            chk({31'h0, gain, inv}, {31'h0, k[1:0], k[2] && k[1:0] == 2'h0});
            rdr(8'h0C, 32'h20, 32'h20);
        end
        wr(8'h08, 8'h21);
        repeat (600) @(posedge aclk);
        wr(8'h0C, 8'h01);
        repeat (600) @(posedge aclk);
        rdr(8'h0C, 32'h20, 32'h20);
        chk({30'h0, ch}, {30'h0, 4'h1});
        poll(5, 1'b0);
        for (int i = 0; i < 3; i++) run(i == 1 ? 2 : 1, i == 1 ? 2 : 1);
        rdr(8'h14, 32'h06, 32'hFFFFFFFF);
        drain();
        rdr(8'h14, 32'h00, 32'hFFFFFFFF);
        wr(8'h10, 8'h01);
        wr(8'h00, 8'h80);
        rdr(8'h0C, 32'h00, 32'h80);
        tmr <= 1'b1;
        repeat (3) @(posedge aclk);
        tmr <= 1'b0;
        poll(7, 1'b0);
        res_q.push_back(base ^ 16'h2);
        wr(8'h10, 8'h11);
        ext <= 1'b1;
        repeat (3) @(posedge aclk);
        ext <= 1'b0;
        poll(7, 1'b0);
        res_q.push_back(base ^ 16'h1);
        drain();
        wr(8'h10, 8'h00);
        wr(8'h0C, 8'h04);
        wr(8'h08, 8'h30);
        poll(5, 1'b0);
        base <= 16'($urandom);
        wr(8'h00, 8'h80);
        repeat (1200) @(posedge aclk);
        rdr(8'h0C, 32'h80, 32'h80);
        poll(7, 1'b0);
        for (int c = 0; c < 4; c++) res_q.push_back(base ^ 16'(c));
        rdr(8'h14, 32'h08, 32'hFFFFFFFF);
        drain();
        wr(8'h08, 8'hF0);
        poll(5, 1'b0);
        for (int i = 0; i < 3; i++) run(0, 15);
        rdr(8'h14, 32'h60, 32'hFFFFFFFF);
        wr(8'h00, 8'h80);
        poll(7, 1'b0);
        rdr(8'h14, 32'hE0, 32'hFFFFFFFF);
        drain();
        wr(8'h18, 8'h01);
        rdr(8'h14, 32'h00, 32'hFFFFFFFF);
        report_and_stop();
    end
endmodule
bind acs_top acs_top_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .conv_channel(conv_channel), .gain_code(gain_code), .range_invalid(range_invalid));
